// ---- common/pfcrx_pkg.sv ----
// Constants for the receive priority flow control block
`default_nettype none
package pfcrx_pkg;
  localparam int NPRI = 8;
  localparam int AW = 6;
  localparam int DW = 32;
  localparam int QW = 16;
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STA_LO = 6'h04;
  localparam logic [5:0] OFF_STA_HI = 6'h08;
  localparam logic [5:0] OFF_STATUS = 6'h0C;
  localparam logic [5:0] OFF_QCFG0 = 6'h10;
  // Control fields
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_LEN_DIS = 1;
  localparam int CTRL_AUTO_XON = 2;
  localparam int CTRL_SPD_LO = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0011;
  localparam logic [1:0] SPD_10M = 2'h0;
  localparam logic [1:0] SPD_100M = 2'h1;
  // Per priority quanta config: quanta high half, refresh low half
  localparam logic [15:0] QUANTA_RST = 16'hFFFF;
  localparam logic [15:0] REFRESH_RST = 16'hFF00;
  localparam logic [47:0] STA_RST = 48'h0000_0000_0000;
  // Frame fields
  localparam logic [47:0] CTRL_MC_DA = 48'h01_00_00_C2_80_01;
  localparam logic [15:0] TYPE_MACCTL = 16'h8808;
  localparam logic [15:0] OPC_PFC = 16'h0101;
  localparam logic [6:0] POS_TYPE = 7'h0C;
  localparam logic [6:0] POS_OPC = 7'h0E;
  localparam logic [6:0] POS_PEV = 7'h10;
  localparam logic [6:0] POS_QNT = 7'h12;
  localparam logic [6:0] POS_DA_END = 7'h06;
  localparam logic [6:0] CTL_FRAME_LEN = 7'h40;
  localparam logic [6:0] CNT_MAX = 7'h7F;
  // Quantum timing: 512 bit times
  localparam int QUANTUM_BITS = 512;
  localparam int CLK_MHZ = 125;
  localparam int GIG_BITS_PER_CLK = 1000 / CLK_MHZ;
  localparam int Q_CYC_1G = QUANTUM_BITS / GIG_BITS_PER_CLK;
  localparam int Q_CYC_100M = Q_CYC_1G * 10;
  localparam int Q_CYC_10M_DEF = Q_CYC_100M * 10;
  localparam int TW = 16;
endpackage
`default_nettype wire

// ---- logic/pfcrx_top.sv ----
// Receive priority flow control with transmit refresh and auto XON
//
// Behaviour
// - Control frame is good only with normal checks passed and 64 bytes, unless the length check is disabled.
// - Bad control frame leaves with drop flag on its last beat.
// - Reception off: good control frames pass with drop flag low.
// - Destination must be control multicast or station address.
// - Type field must be the MAC Control type.
// - Opcode must be the priority flow control opcode.
// - Failed decode or reception off: frame ignored, passed unchanged.
// - Good frame: take enable vector and eight quanta values.
// - Enabled non-zero quanta loads counter and raises pause valid.
// - Counters count down to zero and stop.
// - Pause valid stays high while the counter is non-zero.
// - Loaded counter holds until the acknowledge is high.
// - Acknowledge falling later does not halt the countdown.
// - Counter at zero without reload drops pause valid.
// - Enabled zero quanta clears counter and valid at once.
// - Acted-on pause frame is forwarded with drop flag high.
// - Quanta setting resets to 0xFFFF; refresh frame each refresh span.
// - Refresh setting resets to 0xFF00, below the quanta.
// - XOFF release with auto XON sends zero quanta frame.
// - Enable field is 16 bits; only low eight bits used.
// - One quantum is 512 bit times; counters step per quantum.
`timescale 1ns/10ps
`default_nettype none
module pfcrx_top #(
  parameter int Q_CYC_10M = pfcrx_pkg::Q_CYC_10M_DEF
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  input  wire logic [pfcrx_pkg::AW-1:0]      reg_addr_in,
  input  wire logic [pfcrx_pkg::DW-1:0]      reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [pfcrx_pkg::DW-1:0]      reg_rdata_out,
  input  wire logic [7:0]                    rx_data_in,
  input  wire logic                          rx_valid_in,
  input  wire logic                          rx_last_in,
  input  wire logic                          rx_good_in,
  output logic      [7:0]                    rx_frame_data_out,
  output logic                               rx_frame_valid_out,
  output logic                               rx_frame_last_out,
  output logic                               rx_frame_drop_flag_out,
  output logic      [pfcrx_pkg::NPRI-1:0]    rx_priority_pause_valid_out,
  input  wire logic [pfcrx_pkg::NPRI-1:0]    rx_priority_pause_ack_in,
  input  wire logic [pfcrx_pkg::NPRI-1:0]    tx_priority_xoff_request_in,
  output logic                               tx_frame_req_out,
  input  wire logic                          tx_frame_ack_in,
  output logic      [pfcrx_pkg::NPRI-1:0]    tx_frame_enables_out,
  output logic      [pfcrx_pkg::NPRI-1:0]    tx_frame_zero_out,
  output logic      [pfcrx_pkg::NPRI*16-1:0] tx_frame_quanta_out
);
  import pfcrx_pkg::*;

  if (Q_CYC_10M < Q_CYC_100M) begin : g_chk
    $error("Q_CYC_10M below the 100M quantum count");
  end

  // Register file
  logic [31:0]          ctrl_r;
  logic [47:0]          sta_r;
  logic [NPRI-1:0][QW-1:0] quanta_r;
  logic [NPRI-1:0][QW-1:0] refresh_r;
  logic [31:0]          rdata_r;
  logic [31:0]          rd_mux;
  logic [NPRI-1:0]      pause_valid_r;
  logic [NPRI-1:0]      held_r;
  logic                 req_r;

  wire rx_en = ctrl_r[CTRL_RX_EN];
  wire len_dis = ctrl_r[CTRL_LEN_DIS];
  wire auto_xon = ctrl_r[CTRL_AUTO_XON];
  wire [1:0] speed = ctrl_r[CTRL_SPD_LO +: 2];
  wire addr_qcfg = reg_addr_in >= OFF_QCFG0 &&
                   reg_addr_in < OFF_QCFG0 + 6'(4 * NPRI);
  wire [2:0] qidx = 3'((reg_addr_in - OFF_QCFG0) >> 2);

  always_comb begin
    rd_mux = '0;
    if (reg_addr_in == OFF_CTRL) begin
      rd_mux = ctrl_r;
    end else if (reg_addr_in == OFF_STA_LO) begin
      rd_mux = sta_r[31:0];
    end else if (reg_addr_in == OFF_STA_HI) begin
      rd_mux = {16'h0000, sta_r[47:32]};
    end else if (reg_addr_in == OFF_STATUS) begin
      rd_mux = {15'h0000, req_r, held_r, pause_valid_r};
    end else if (addr_qcfg) begin
      rd_mux = {quanta_r[qidx], refresh_r[qidx]};
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= CTRL_RST;
      sta_r <= STA_RST;
      rdata_r <= '0;
      for (int i = 0; i < NPRI; i++) begin
        quanta_r[i] <= QUANTA_RST;
        refresh_r[i] <= REFRESH_RST;
      end
    end else begin
      rdata_r <= reg_rd_in ? rd_mux : '0;
      if (reg_wr_in) begin
        if (reg_addr_in == OFF_CTRL) begin
          ctrl_r <= reg_wdata_in;
        end else if (reg_addr_in == OFF_STA_LO) begin
          sta_r[31:0] <= reg_wdata_in;
        end else if (reg_addr_in == OFF_STA_HI) begin
          sta_r[47:32] <= reg_wdata_in[15:0];
        end else if (addr_qcfg) begin
          quanta_r[qidx] <= reg_wdata_in[31:16];
          refresh_r[qidx] <= reg_wdata_in[15:0];
        end
      end
    end
  end

  // Quantum tick, 512 bit times at the selected speed
  logic [TW-1:0] tick_cnt_r;
  wire [TW-1:0] q_len = speed == SPD_10M ? TW'(Q_CYC_10M) :
                        speed == SPD_100M ? TW'(Q_CYC_100M) :
                        TW'(Q_CYC_1G);
  wire tick = tick_cnt_r >= q_len - 1'b1;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // Receive frame parse
  function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                           input logic [6:0] i);
    addr_byte = a[8 * i[2:0] +: 8];
  endfunction

  logic [6:0]           bcnt_r;
  logic                 da_mc_r;
  logic                 da_st_r;
  logic [15:0]          type_r;
  logic [15:0]          opc_r;
  logic [15:0]          pev_r;
  logic [NPRI-1:0][QW-1:0] rxq_r;
  logic                 hi_r;

  wire beat = rx_valid_in;
  wire in_da = bcnt_r < POS_DA_END;
  wire mc_hit = rx_data_in == addr_byte(CTRL_MC_DA, bcnt_r);
  wire st_hit = rx_data_in == addr_byte(sta_r, bcnt_r);
  wire [6:0] qoff = bcnt_r - POS_QNT;
  wire in_q = bcnt_r >= POS_QNT &&
              bcnt_r < POS_QNT + 7'(2 * NPRI);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bcnt_r <= '0;
      da_mc_r <= 1'b1;
      da_st_r <= 1'b1;
      type_r <= '0;
      opc_r <= '0;
      pev_r <= '0;
      rxq_r <= '0;
      hi_r <= 1'b0;
    end else if (beat) begin
      bcnt_r <= rx_last_in ? '0 :
                (bcnt_r == CNT_MAX ? bcnt_r : bcnt_r + 1'b1);
      da_mc_r <= rx_last_in | (da_mc_r & (~in_da | mc_hit));
      da_st_r <= rx_last_in | (da_st_r & (~in_da | st_hit));
      if (bcnt_r == POS_TYPE || bcnt_r == POS_TYPE + 1'b1) begin
        type_r <= {type_r[7:0], rx_data_in};
      end
      if (bcnt_r == POS_OPC || bcnt_r == POS_OPC + 1'b1) begin
        opc_r <= {opc_r[7:0], rx_data_in};
      end
      if (bcnt_r == POS_PEV || bcnt_r == POS_PEV + 1'b1) begin
        pev_r <= {pev_r[7:0], rx_data_in};
      end
      if (in_q) begin
        rxq_r[qoff[3:1]] <= {rxq_r[qoff[3:1]][7:0], rx_data_in};
      end
    end
  end

  // Decisions on the last beat
  wire is_ctl = type_r == TYPE_MACCTL;
  wire len_ok = bcnt_r == CTL_FRAME_LEN - 1'b1 || len_dis;
  wire ctl_err = is_ctl & (~rx_good_in | ~len_ok);
  wire ctl_good = is_ctl & rx_good_in & len_ok;
  wire da_ok = da_mc_r | da_st_r;
  wire opc_ok = opc_r == OPC_PFC;
  wire act = beat & rx_last_in & ctl_good & da_ok & opc_ok & rx_en;
  wire [NPRI-1:0] load_en = act ? pev_r[NPRI-1:0] : '0;
  wire drop = ~rx_good_in | ctl_err | (ctl_good & da_ok & opc_ok & rx_en);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_frame_data_out <= '0;
      rx_frame_valid_out <= 1'b0;
      rx_frame_last_out <= 1'b0;
      rx_frame_drop_flag_out <= 1'b0;
    end else begin
      rx_frame_data_out <= rx_data_in;
      rx_frame_valid_out <= beat;
      rx_frame_last_out <= beat & rx_last_in;
      rx_frame_drop_flag_out <= beat & rx_last_in & drop;
    end
  end

  // Per priority pause counters
  logic [NPRI-1:0][QW-1:0] pcnt_r;
  logic [NPRI-1:0]      run_r;

  for (genvar p = 0; p < NPRI; p++) begin : g_rx
    wire nz = pcnt_r[p] != '0;
    wire go = run_r[p] | rx_priority_pause_ack_in[p];
    wire [QW-1:0] dec = pcnt_r[p] - 1'b1;
    wire [QW-1:0] cnt_nxt = load_en[p] ? rxq_r[p] :
                            (nz & go & tick ? dec : pcnt_r[p]);
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        pcnt_r[p] <= '0;
        run_r[p] <= 1'b0;
        pause_valid_r[p] <= 1'b0;
      end else begin
        pcnt_r[p] <= cnt_nxt;
        run_r[p] <= ~load_en[p] & nz & go;
        pause_valid_r[p] <= cnt_nxt != '0;
      end
    end
  end

  assign rx_priority_pause_valid_out = pause_valid_r;

  // Transmit request tracking: XOFF, refresh and auto XON
  logic [NPRI-1:0]      xoff_prev_r;
  logic [NPRI-1:0]      pend_r;
  logic [NPRI-1:0]      zero_r;
  logic [NPRI-1:0][QW-1:0] elap_r;
  logic [NPRI-1:0]      en_r;
  logic [NPRI-1:0]      zo_r;

  wire sent = req_r & tx_frame_ack_in;
  wire [NPRI-1:0] xoff = tx_priority_xoff_request_in;
  wire [NPRI-1:0] rise = xoff & ~xoff_prev_r;
  wire [NPRI-1:0] xon = ~xoff & held_r & {NPRI{auto_xon}};
  logic [NPRI-1:0] refr;

  for (genvar p = 0; p < NPRI; p++) begin : g_tx
    assign refr[p] = held_r[p] & elap_r[p] >= refresh_r[p];
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        elap_r[p] <= '0;
      end else if (sent | ~held_r[p] | refr[p]) begin
        elap_r[p] <= '0;
      end else if (tick) begin
        elap_r[p] <= elap_r[p] + 1'b1;
      end
    end
  end

  wire [NPRI-1:0] ev = rise | xon | refr;
  wire [NPRI-1:0] pend_nxt = (sent ? '0 : pend_r) | ev;
  wire [NPRI-1:0] zero_nxt = ((sent ? '0 : zero_r) | xon) & ~rise;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      xoff_prev_r <= '0;
      held_r <= '0;
      pend_r <= '0;
      zero_r <= '0;
      req_r <= 1'b0;
      en_r <= '0;
      zo_r <= '0;
    end else begin
      xoff_prev_r <= xoff;
      held_r <= xoff & (xoff_prev_r | held_r);
      pend_r <= pend_nxt;
      zero_r <= zero_nxt;
      req_r <= pend_nxt != '0;
      en_r <= pend_nxt | (held_r & xoff);
      zo_r <= zero_nxt;
    end
  end

  assign tx_frame_req_out = req_r;
  assign tx_frame_enables_out = en_r;
  assign tx_frame_zero_out = zo_r;
  assign tx_frame_quanta_out = quanta_r;
  assign reg_rdata_out = rdata_r;
endmodule
`default_nettype wire

// ---- verification/pfcrx_props.sv ----
// Port checker for receive priority flow control
`timescale 1ns/10ps
`default_nettype none
module pfcrx_props #(parameter int Q_CYC_10M = 640) (
  input wire logic         core_clk_in,
  input wire logic         rst_in,
  input wire logic [7:0]   rx_data_in,
  input wire logic         rx_valid_in,
  input wire logic         rx_last_in,
  input wire logic         rx_good_in,
  input wire logic [7:0]   rx_frame_data_out,
  input wire logic         rx_frame_last_out,
  input wire logic         rx_frame_drop_flag_out,
  input wire logic [7:0]   rx_priority_pause_valid_out,
  input wire logic [7:0]   rx_priority_pause_ack_in,
  input wire logic         tx_frame_req_out,
  input wire logic         tx_frame_ack_in,
  input wire logic [127:0] tx_frame_quanta_out
);
  wire logic [7:0] pv = rx_priority_pause_valid_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_drop_on_last: assert property (rx_frame_drop_flag_out |-> rx_frame_last_out)
    else $error("drop flag off last beat");
  a_bad_drop: assert property (rx_valid_in && rx_last_in && !rx_good_in |=>
    rx_frame_drop_flag_out) else $error("bad frame not dropped");
  a_stream_delay: assert property (rx_valid_in |=>
    rx_frame_data_out == $past(rx_data_in) &&
    rx_frame_last_out == $past(rx_last_in)) else $error("stream altered");
  a_hold_no_ack: assert property ($rose(pv[0]) ##0
    (!rx_priority_pause_ack_in[0] && !rx_valid_in)[*8] |=> pv[0])
    else $error("pause ran without ack");
  a_rise_on_frame: assert property (|(pv & ~$past(pv)) |->
    $past(rx_valid_in && rx_last_in && rx_good_in))
    else $error("pause rose without frame");
  a_acted_drop: assert property (|(pv & ~$past(pv)) |-> rx_frame_drop_flag_out)
    else $error("acted frame not dropped");
  a_req_until_ack: assert property (tx_frame_req_out && !tx_frame_ack_in |=>
    tx_frame_req_out) else $error("request left before ack");
  a_quanta_reset: assert property ($fell(rst_in) |->
    tx_frame_quanta_out == {8{16'hFFFF}} && pv == 8'h00)
    else $error("bad reset quanta");
  cover property ($fell(pv[0]));
  cover property (tx_frame_req_out && tx_frame_ack_in);
  cover property (rx_frame_drop_flag_out);
endmodule
bind pfcrx_top pfcrx_props #(.Q_CYC_10M(Q_CYC_10M)) i_props (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .rx_data_in(rx_data_in),
  .rx_valid_in(rx_valid_in), .rx_last_in(rx_last_in),
  .rx_good_in(rx_good_in), .rx_frame_data_out(rx_frame_data_out),
  .rx_frame_last_out(rx_frame_last_out),
  .rx_frame_drop_flag_out(rx_frame_drop_flag_out),
  .rx_priority_pause_valid_out(rx_priority_pause_valid_out),
  .rx_priority_pause_ack_in(rx_priority_pause_ack_in),
  .tx_frame_req_out(tx_frame_req_out), .tx_frame_ack_in(tx_frame_ack_in),
  .tx_frame_quanta_out(tx_frame_quanta_out));
`default_nettype wire

// ---- verification/pfcrx_partner.sv ----
// Client model: pause acknowledge and transmit frame take
`timescale 1ns/10ps
`default_nettype none
module pfcrx_partner (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] ack_mask_in,
  input  wire logic [3:0] tx_delay_in,
  input  wire logic [7:0] pause_valid_in,
  input  wire logic       frame_req_in,
  output logic      [7:0] pause_ack_out,
  output logic            frame_ack_out
);
  logic [3:0] wait_r;
  wire logic  busy = frame_req_in && !frame_ack_out;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pause_ack_out <= 8'h00;
      wait_r        <= 4'h0;
      frame_ack_out <= 1'b0;
    end else begin
      pause_ack_out <= pause_valid_in & ack_mask_in;
      frame_ack_out <= busy && wait_r >= tx_delay_in;
      wait_r        <= (busy && wait_r < tx_delay_in) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ---- verification/pfcrx_bench.sv ----
// Bench for receive priority flow control
`timescale 1ns/10ps
`default_nettype none
module pfcrx_bench;
  import pfcrx_pkg::*;
  logic         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [5:0]   addr = 6'h00;
  logic [31:0]  wdata = 32'h0, rdata;
  logic [7:0]   rxd = 8'h00, fd, pv, ack, xoff = 8'h00, ten, tz, mask = 8'hFF;
  logic         rxv = 1'b0, rxl = 1'b0, rxg = 1'b0, fv, fl, fdrop, treq, tack;
  logic [127:0] tq;
  int           fails = 0, comparisons = 0, n;
  always #4 clk = ~clk;
  pfcrx_top #(.Q_CYC_10M(640)) i_dut (.core_clk_in(clk), .rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .rx_data_in(rxd), .rx_valid_in(rxv),
    .rx_last_in(rxl), .rx_good_in(rxg), .rx_frame_data_out(fd),
    .rx_frame_valid_out(fv), .rx_frame_last_out(fl),
    .rx_frame_drop_flag_out(fdrop), .rx_priority_pause_valid_out(pv),
    .rx_priority_pause_ack_in(ack), .tx_priority_xoff_request_in(xoff),
    .tx_frame_req_out(treq), .tx_frame_ack_in(tack),
    .tx_frame_enables_out(ten), .tx_frame_zero_out(tz),
    .tx_frame_quanta_out(tq));
  pfcrx_partner i_partner (.core_clk_in(clk), .rst_in(rst),
    .ack_mask_in(mask), .tx_delay_in(4'h2), .pause_valid_in(pv),
    .frame_req_in(treq), .pause_ack_out(ack), .frame_ack_out(tack));
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a, input logic [31:0] e, string s);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(s, e, rdata);
  endtask
  task automatic frame(input logic [47:0] da, input logic [15:0] ty, op,
      input logic [7:0] pe, input logic [15:0] q, input int p, len,
      input logic g, dr);
    logic [271:0] h;
    // Address goes out low byte first, as the parser indexes it
    h = {da[7:0], da[15:8], da[23:16], da[31:24], da[39:32], da[47:40],
         48'h0, ty, op, 8'h00, pe, 128'(q) << (16 * (7 - p))};
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      rxv <= 1'b1;
      rxd <= (i < 34) ? h[271 - 8 * i -: 8] : 8'(i);
      rxl <= (i == len - 1);
      rxg <= g;
    end
    @(posedge clk);
    rxv <= 1'b0;
    rxl <= 1'b0;
    rxd <= ~rxd;
    #1 chk("last beat", {2'b11, dr, 8'(len - 1)}, {fv, fl, fdrop, fd});
  endtask
  task automatic wait_until(input logic [8:0] m, v, input int lim);
    #1;
    for (n = 0; n < lim && ({treq, pv} & m) !== v; n++) begin
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rreg(OFF_CTRL, CTRL_RST, "ctrl");
    rreg(OFF_QCFG0, {QUANTA_RST, REFRESH_RST}, "qcfg0");
    rreg(6'h3C, 32'h0, "unmapped");
    wreg(OFF_STATUS, 32'hFFFF_FFFF);
    rreg(OFF_STATUS, 32'h0, "status");
    wreg(OFF_STA_LO, 32'h3322_1102);
    wreg(OFF_STA_HI, 32'h0000_5544);
    $display("registers done");
    for (int k = 0; k < 7; k++) begin
      wreg(OFF_CTRL, k == 5 ? 32'h10 : k == 6 ? 32'h13 : 32'h11);
      frame(k == 2 ? 48'h02_00_00_00_00_01 : CTRL_MC_DA,
            k == 0 ? 16'h0800 : TYPE_MACCTL,
            k == 1 || k == 6 ? 16'h0001 : OPC_PFC, 8'h01, 16'h0005, 0,
            k == 4 || k == 6 ? 65 : 64, k != 3, k == 3 || k == 4);
      chk("ignored frame", 8'h00, pv);
    end
    wreg(OFF_CTRL, CTRL_RST);
    $display("decode done");
    frame(CTRL_MC_DA, TYPE_MACCTL, OPC_PFC, 8'h01, 16'h0002, 0, 64, 1, 1);
    chk("pause valid", 8'h01, pv);
    wait_until(9'h001, 9'h000, 400);
    chk("pause span", 1, n >= Q_CYC_1G && n <= 3 * Q_CYC_1G);
    mask <= 8'h00;
    frame(48'h55_44_33_22_11_02, TYPE_MACCTL, OPC_PFC, 8'h01, 16'h0003, 0,
          64, 1, 1);
    repeat (200) @(posedge clk);
    mask <= 8'hFF;
    #1 chk("held pause", 8'h01, pv);
    repeat (100) @(posedge clk);
    mask <= 8'h00;
    wait_until(9'h001, 9'h000, 300);
    chk("pause after ack drop", 8'h00, pv);
    mask <= 8'hFF;
    frame(CTRL_MC_DA, TYPE_MACCTL, OPC_PFC, 8'h08, 16'h0100, 3, 64, 1, 1);
    frame(CTRL_MC_DA, TYPE_MACCTL, OPC_PFC, 8'h10, 16'h0100, 4, 64, 1, 1);
    chk("two pauses", 8'h18, pv);
    frame(CTRL_MC_DA, TYPE_MACCTL, OPC_PFC, 8'h08, 16'h0000, 3, 64, 1, 1);
    wait_until(9'h008, 9'h000, 1);
    chk("zero quanta", 8'h10, pv);
    frame(CTRL_MC_DA, TYPE_MACCTL, OPC_PFC, 8'h10, 16'h0000, 4, 64, 1, 1);
    wreg(OFF_CTRL, 32'h09);
    frame(CTRL_MC_DA, TYPE_MACCTL, OPC_PFC, 8'h01, 16'h0002, 0, 64, 1, 1);
    wait_until(9'h001, 9'h000, 1400);
    chk("100M span", 1, n >= Q_CYC_100M && n <= 2 * Q_CYC_100M + 2);
    $display("receive done");
    wreg(OFF_QCFG0, 32'hFFFF_0002);
    wreg(OFF_CTRL, 32'h15);
    xoff <= 8'h01;
    wait_until(9'h100, 9'h100, 4);
    chk("xoff frame", 9'h101, {treq, ten});
    chk("quanta out", QUANTA_RST, tq[15:0]);
    wait_until(9'h100, 9'h000, 20);
    wait_until(9'h100, 9'h100, 400);
    chk("refresh frame", 1, n > Q_CYC_1G && n < 400);
    wait_until(9'h100, 9'h000, 20);
    @(posedge clk);
    xoff <= 8'h00;
    wait_until(9'h100, 9'h100, 4);
    chk("xon frame", 2'b11, {treq, tz[0]});
    wait_until(9'h100, 9'h000, 20);
    wreg(OFF_CTRL, CTRL_RST);
    xoff <= 8'h01;
    wait_until(9'h100, 9'h100, 4);
    wait_until(9'h100, 9'h000, 20);
    @(posedge clk);
    xoff <= 8'h00;
    wait_until(9'h100, 9'h100, 20);
    chk("no xon frame", 20, n);
    $display("transmit done");
    test_done;
  end
  initial begin
    #160000;
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
